//--- bpmm_mode_manager.sv
`timescale 1ns/1ps
// Power mode manager: Run, Sample, low-voltage Sleep, storage sleep
module bpmm_mode_manager
  import bpmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [DATA_W-1:0] rdData,
  input wire logic measTick,
  input wire logic [15:0] currMag,
  input wire logic [15:0] packVoltageInput,
  input wire logic shelfCmd,
  input wire logic ioActivity,
  input wire logic busActivity,
  input wire logic smbClkIn,
  input wire logic smbDataIn,
  output logic [1:0] powerMode,
  output logic measureEn,
  output logic calcEn,
  output logic displayEn,
  output logic smbAccept,
  output logic remcapZero,
  output logic ultraLowPower
);
  // ==========================================================
  // Configuration registers
  logic [7:0] wakeCfg_reg, wakeCfg_next;
  logic [7:0] wakeLvl_reg, wakeLvl_next;
  logic [15:0] sleepV_reg, sleepV_next;
  logic [15:0] runThr_reg, runThr_next;
  logic [7:0] sample_interval_periods_reg, sample_interval_periods_next;
  logic sampleEn_reg, sampleEn_next;
  logic [DATA_W-1:0] rdData_reg, rdData_next;

  // ==========================================================
  // Mode state and registered outputs
  bpmm_mode_t mode_reg, mode_next;
  logic measureEn_reg, measureEn_next;
  logic calcEn_reg, calcEn_next;
  logic displayEn_reg, displayEn_next;
  logic smbAccept_reg, smbAccept_next;
  logic remcapZero_reg, remcapZero_next;
  logic ulp_reg, ulp_next;

  logic runReq, sampleReq, sampleFire, measNow, timerRestart;
  logic smbHigh, anySrc, shelfWake, lvWake, currAbove;
  logic [15:0] wake_on_voltage, wake_on_current;

  // ==========================================================
  // Register writes; strobes never overlap, so one path each
  always_comb
  begin
    wakeCfg_next = wakeCfg_reg;
    wakeLvl_next = wakeLvl_reg;
    sleepV_next = sleepV_reg;
    runThr_next = runThr_reg;
    sample_interval_periods_next = sample_interval_periods_reg;
    sampleEn_next = sampleEn_reg;
    if (wrStrobe)
    begin
      case (addr)
        OFS_WAKE_CFG: wakeCfg_next = wrData[7:0];
        OFS_WAKE_LVL: wakeLvl_next = wrData[7:0];
        OFS_SLEEP_V: sleepV_next = wrData;
        OFS_RUN_THR: runThr_next = wrData;
        OFS_SAMPLE_INTERVAL_PERIODS: sample_interval_periods_next = wrData[7:0];
        OFS_CTRL: sampleEn_next = wrData[CTRL_SAMPLE_EN];
        default: ;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_comb
  begin
    rdData_next = 16'h0000;
    if (rdStrobe)
    begin
      case (addr)
        OFS_WAKE_CFG: rdData_next = {8'h00, wakeCfg_reg};
        OFS_WAKE_LVL: rdData_next = {8'h00, wakeLvl_reg};
        OFS_SLEEP_V: rdData_next = sleepV_reg;
        OFS_RUN_THR: rdData_next = runThr_reg;
        OFS_SAMPLE_INTERVAL_PERIODS: rdData_next = {8'h00, sample_interval_periods_reg};
        OFS_CTRL: rdData_next = {15'h0000, sampleEn_reg};
        OFS_STATUS: rdData_next = {13'h0000, ulp_reg, mode_reg};
        default: rdData_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wakeCfg_reg <= RST_WAKE_CFG;
      wakeLvl_reg <= RST_WAKE_LVL;
      sleepV_reg <= RST_SLEEP_V;
      runThr_reg <= RST_RUN_THR;
      sample_interval_periods_reg <= RST_SAMPLE_INTERVAL_PERIODS;
      sampleEn_reg <= 1'b1;
      rdData_reg <= 16'h0000;
    end
    else
    begin
      wakeCfg_reg <= wakeCfg_next;
      wakeLvl_reg <= wakeLvl_next;
      sleepV_reg <= sleepV_next;
      runThr_reg <= runThr_next;
      sample_interval_periods_reg <= sample_interval_periods_next;
      sampleEn_reg <= sampleEn_next;
      rdData_reg <= rdData_next;
    end
  end

  // ==========================================================
  // Measurement scheduling
  assign timerRestart = (mode_reg != BPMM_SAMPLE); // RULE19
  assign measNow = measTick && (mode_reg == BPMM_RUN || sampleFire); // RULE15
  assign currAbove = (currMag > runThr_reg); // RULE14

  bpmm_sample_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .restart(timerRestart),
    .tick(measTick),
    .interval(sample_interval_periods_reg),
    .fire(sampleFire)
  );

  bpmm_debounce u_deb (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(isSleep(mode_reg)),
    .strobe(measNow),
    .above(currAbove),
    .runReq(runReq),
    .sampleReq(sampleReq)
  );

  // ==========================================================
  // Wake conditions
  assign wake_on_voltage = wakeMv(wakeLvl_reg[2:0]); // RULE12
  // Threshold scales with the 5-bit code, 0 is the most sensitive
  assign wake_on_current = 16'(wakeLvl_reg[7:3]) * WAKE_CURR_STEP; // RULE13
  assign smbHigh = smbClkIn && smbDataIn;
  assign anySrc = |wakeCfg_reg[CFG_IO:CFG_VOLT];
  // Low-voltage wake picks voltage or the SMBus pull-up
  assign lvWake = wakeCfg_reg[CFG_LV_ULP] ? smbHigh // RULE5
                : (packVoltageInput > wake_on_voltage); // RULE4
  // Bit 3 only counts when no source is enabled
  always_comb
  begin
    shelfWake = 1'b0;
    if (anySrc) // RULE8
      shelfWake = (wakeCfg_reg[CFG_IO] && ioActivity) // RULE7
               || (wakeCfg_reg[CFG_BUS] && busActivity)
               || (wakeCfg_reg[CFG_CURR] && (currMag > wake_on_current))
               || (wakeCfg_reg[CFG_VOLT] && (packVoltageInput > wake_on_voltage));
    else if (wakeCfg_reg[CFG_SHELF_ULP]) // RULE9 RULE10
      shelfWake = smbHigh;
  end

  // ==========================================================
  // Mode machine; a stored shelf mode with no wake path holds to reset
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      BPMM_RUN:
      begin
        if (shelfCmd)
          mode_next = BPMM_SHELF; // RULE6
        else if (sampleEn_reg && sampleReq)
          mode_next = BPMM_SAMPLE; // RULE14 RULE17
      end
      BPMM_SAMPLE:
      begin
        if (shelfCmd)
          mode_next = BPMM_SHELF; // RULE6
        else if (measNow && (packVoltageInput < sleepV_reg))
          mode_next = BPMM_LVSLEEP; // RULE1
        else if (runReq || !sampleEn_reg)
          mode_next = BPMM_RUN; // RULE14
      end
      BPMM_LVSLEEP:
      begin
        if (lvWake)
          mode_next = BPMM_RUN; // RULE2
      end
      BPMM_SHELF:
      begin
        if (shelfWake)
          mode_next = BPMM_RUN; // RULE19
      end
      default: mode_next = BPMM_RUN;
    endcase
  end

  // Display and SMBus follow the next mode, measure and calc the current one, so they go quiet a cycle later
  always_comb
  begin
    measureEn_next = measNow && !isSleep(mode_reg); // RULE3
    calcEn_next = measTick && !isSleep(mode_reg); // RULE3 RULE15
    displayEn_next = !isSleep(mode_next); // RULE3
    smbAccept_next = !isSleep(mode_next); // RULE3
    remcapZero_next = (mode_next == BPMM_LVSLEEP)
                   && (mode_reg != BPMM_LVSLEEP)
                   && wakeCfg_reg[CFG_ZERO_REM]; // RULE11
    ulp_next = ((mode_next == BPMM_LVSLEEP) && wakeCfg_reg[CFG_LV_ULP])
            || ((mode_next == BPMM_SHELF) && !anySrc);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= BPMM_RUN;
      measureEn_reg <= 1'b0;
      calcEn_reg <= 1'b0;
      displayEn_reg <= 1'b1;
      smbAccept_reg <= 1'b1;
      remcapZero_reg <= 1'b0;
      ulp_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      measureEn_reg <= measureEn_next;
      calcEn_reg <= calcEn_next;
      displayEn_reg <= displayEn_next;
      smbAccept_reg <= smbAccept_next;
      remcapZero_reg <= remcapZero_next;
      ulp_reg <= ulp_next;
    end
  end

  assign rdData = rdData_reg;
  assign powerMode = mode_reg;
  assign measureEn = measureEn_reg;
  assign calcEn = calcEn_reg;
  assign displayEn = displayEn_reg;
  assign smbAccept = smbAccept_reg;
  assign remcapZero = remcapZero_reg;
  assign ultraLowPower = ulp_reg;

  // ==========================================================
  // Checks
  property p_lv_entry;
    @(posedge mclk) disable iff (!rst_n)
    $rose(mode_reg == BPMM_LVSLEEP) |-> $past(mode_reg) == BPMM_SAMPLE;
  endproperty
  a_lv_entry: assert property (p_lv_entry) // RULE1
    else $error("Sleep entered from a mode other than Sample");

  property p_lv_exit;
    @(posedge mclk) disable iff (!rst_n)
    (mode_reg == BPMM_LVSLEEP) ##1 (mode_reg != BPMM_LVSLEEP)
      |-> mode_reg == BPMM_RUN;
  endproperty
  a_lv_exit: assert property (p_lv_exit) // RULE2
    else $error("Sleep left to a mode other than Run");

  property p_quiet;
    @(posedge mclk) disable iff (!rst_n)
    isSleep(mode_reg) ##1 isSleep(mode_reg)
      |-> !measureEn_reg && !calcEn_reg
        && !displayEn_reg && !smbAccept_reg;
  endproperty
  a_quiet: assert property (p_quiet) // RULE3
    else $error("Activity seen during sleep");

  property p_lv_volt_wake;
    @(posedge mclk) disable iff (!rst_n)
    (mode_reg == BPMM_LVSLEEP) && !wakeCfg_reg[CFG_LV_ULP]
      && (packVoltageInput > wakeMv(wakeLvl_reg[2:0]))
      |=> mode_reg == BPMM_RUN;
  endproperty
  a_lv_volt_wake: assert property (p_lv_volt_wake) // RULE4
    else $error("Voltage wake missed");

  property p_lv_ulp_hold;
    @(posedge mclk) disable iff (!rst_n)
    (mode_reg == BPMM_LVSLEEP) && wakeCfg_reg[CFG_LV_ULP] && !smbHigh
      |=> mode_reg == BPMM_LVSLEEP;
  endproperty
  a_lv_ulp_hold: assert property (p_lv_ulp_hold) // RULE5
    else $error("Ultra low power sleep left without SMBus high");

  property p_shelf_entry;
    @(posedge mclk) disable iff (!rst_n)
    shelfCmd && !isSleep(mode_reg) |=> mode_reg == BPMM_SHELF;
  endproperty
  a_shelf_entry: assert property (p_shelf_entry) // RULE6
    else $error("Shelf command not obeyed");

  property p_remcap;
    @(posedge mclk) disable iff (!rst_n)
    $rose(mode_reg == BPMM_LVSLEEP) && $past(wakeCfg_reg[CFG_ZERO_REM])
      |-> remcapZero_reg ##1 !remcapZero_reg;
  endproperty
  a_remcap: assert property (p_remcap) // RULE11
    else $error("Remaining capacity clear not pulsed");

  property p_run_exit;
    @(posedge mclk) disable iff (!rst_n)
    mode_reg == BPMM_RUN |=> mode_reg != BPMM_LVSLEEP;
  endproperty
  a_run_exit: assert property (p_run_exit) // RULE17
    else $error("Run went straight to Sleep");

  property p_two_meas;
    @(posedge mclk) disable iff (!rst_n)
    (mode_reg == BPMM_RUN) ##1 (mode_reg == BPMM_SAMPLE)
      |-> $past(sampleReq);
  endproperty
  a_two_meas: assert property (p_two_meas) // RULE16
    else $error("Run to Sample without two low measurements");

  c_lv: cover property (@(posedge mclk) $rose(mode_reg == BPMM_LVSLEEP));
  c_shelf: cover property (@(posedge mclk) $rose(mode_reg == BPMM_SHELF));
  c_wake: cover property (@(posedge mclk)
    (mode_reg == BPMM_SHELF) ##1 (mode_reg == BPMM_RUN));
endmodule

//--- bpmm_pkg.sv
// Summary of operation
// [RULE1] Low-voltage Sleep only from Sample, pack voltage below sleep level.
// [RULE2] Low-voltage Sleep exits only to Run, on an enabled wake condition.
// [RULE3] Sleep: no measurements, no calculations, display off, SMBus ignored.
// [RULE4] Default low-voltage Sleep wakes on pack voltage above wake level.
// [RULE5] Config bit 1 set: low-voltage Sleep wakes only on SMBus lines high.
// [RULE6] Host commands storage sleep; entered whatever the pack voltage.
// [RULE7] Storage sleep wakes on enabled bits 7..4: I/O, bus, current, volts.
// [RULE8] Any wake source enabled: storage sleep monitors the chosen sources.
// [RULE9] No source, bit 3 set: storage sleep wakes only on SMBus lines high.
// [RULE10] Programmer keeps other config bits zero when setting bit 3.
// [RULE11] Bit 0 set: remaining capacity zeroed on entering low-voltage Sleep.
// [RULE12] Wake voltage field bits 2:0 decodes eight levels, 6.4 V to 13.3 V.
// [RULE13] Wake current bits 7:3: 00000 min, 11111 max, 11000 recommended.
// [RULE14] Current above run/sample threshold picks Run, below picks Sample.
// [RULE15] Sample mode measures once per interval; calculations every period.
// [RULE16] Run/Sample change only after two agreeing measurements in a row. Code: Sample also goes to Run at once when Sample is disabled.
// [RULE17] With Sample enabled, Run exits only to Sample, never to Sleep. Code: Run also goes to storage sleep on shelfCmd.
// [RULE18] Programmer sets sample interval to at least two periods.
// [RULE19] Wake from storage sleep resumes Run, measuring from next period.
package bpmm_pkg;
  // ==========================================================
  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFS_WAKE_CFG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_WAKE_LVL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_V = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RUN_THR = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_SAMPLE_INTERVAL_PERIODS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h6;
  // ==========================================================
  // Field positions and reset values
  localparam int CFG_IO = 7;
  localparam int CFG_BUS = 6;
  localparam int CFG_CURR = 5;
  localparam int CFG_VOLT = 4;
  localparam int CFG_SHELF_ULP = 3;
  localparam int CFG_LV_ULP = 1;
  localparam int CFG_ZERO_REM = 0;
  localparam int CTRL_SAMPLE_EN = 0;
  localparam logic [7:0] RST_WAKE_CFG = 8'h00;
  localparam logic [7:0] RST_WAKE_LVL = 8'hC0;
  localparam logic [15:0] RST_SLEEP_V = 16'h1770;
  localparam logic [15:0] RST_RUN_THR = 16'h0014;
  localparam logic [7:0] RST_SAMPLE_INTERVAL_PERIODS = 8'h10;
  localparam logic [7:0] SAMPLE_INTERVAL_PERIODS_MIN = 8'h02;
  localparam logic [15:0] WAKE_CURR_STEP = 16'h0004;
  // ==========================================================
  // Power modes
  typedef enum logic [1:0] {
    BPMM_RUN = 2'b00,
    BPMM_SAMPLE = 2'b01,
    BPMM_LVSLEEP = 2'b10,
    BPMM_SHELF = 2'b11
  } bpmm_mode_t;

  // Wake voltage level in mV from the 3-bit code
  function automatic logic [15:0] wakeMv(input logic [2:0] code);
    case (code)
      3'h0: wakeMv = 16'h1900;
      3'h1: wakeMv = 16'h1A04;
      3'h2: wakeMv = 16'h22B0;
      3'h3: wakeMv = 16'h2580;
      3'h4: wakeMv = 16'h2706;
      3'h5: wakeMv = 16'h2B5C;
      3'h6: wakeMv = 16'h3200;
      default: wakeMv = 16'h33F4;
    endcase
  endfunction

  function automatic logic isSleep(input bpmm_mode_t m);
    isSleep = (m == BPMM_LVSLEEP) || (m == BPMM_SHELF);
  endfunction
endpackage

//--- bpmm_debounce.sv
`timescale 1ns/1ps
// Two-in-a-row qualifier for the run/sample current comparison
module bpmm_debounce
  import bpmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic strobe,
  input wire logic above,
  output logic runReq,
  output logic sampleReq
);
  logic [1:0] hist_reg, hist_next;
  logic [1:0] cnt_reg, cnt_next;

  // ==========================================================
  // History of the last two compares
  always_comb
  begin
    hist_next = hist_reg;
    cnt_next = cnt_reg;
    if (clear)
    begin
      cnt_next = 2'h0;
    end
    else if (strobe)
    begin
      hist_next = {hist_reg[0], above};
      cnt_next = (cnt_reg == 2'h2) ? 2'h2 : cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hist_reg <= 2'h0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      hist_reg <= hist_next;
      cnt_reg <= cnt_next;
    end
  end

  // Both of the last two agree before a change is asked for
  assign runReq = (cnt_reg == 2'h2) && (hist_reg == 2'h3); // RULE16
  assign sampleReq = (cnt_reg == 2'h2) && (hist_reg == 2'h0); // RULE16
endmodule

//--- bpmm_sample_timer.sv
`timescale 1ns/1ps
// Counts measurement periods in Sample mode
module bpmm_sample_timer
  import bpmm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic tick,
  input wire logic [7:0] interval,
  output logic fire
);
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] lim;

  // A value of 1 would measure every period and 0 only every 256; clamp both to two
  assign lim = (interval < SAMPLE_INTERVAL_PERIODS_MIN) ? SAMPLE_INTERVAL_PERIODS_MIN : interval; // RULE18

  always_comb
  begin
    cnt_next = cnt_reg;
    if (restart)
      cnt_next = 8'h00;
    else if (tick)
      cnt_next = (cnt_reg == lim - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end

  assign fire = tick && !restart && (cnt_reg == lim - 8'h01); // RULE15
endmodule

//--- bpmm_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host side of the SMBus; the pack sits out of the host between requests
module bpmm_host_model
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sendShelf,
  input wire logic talk,
  input wire logic pullHigh,
  output logic shelfCmd,
  output logic busActivity,
  output logic smbClkIn,
  output logic smbDataIn
);
  logic last_reg;
  logic last_next;
  logic flip_reg;
  logic flip_next;

  // Request edge memory and a data pattern that never rests on one level
  always_comb
  begin
    last_next = sendShelf;
    flip_next = ~flip_reg;
  end

  // Registers only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      last_reg <= 1'b0;
      flip_reg <= 1'b0;
    end
    else
    begin
      last_reg <= last_next;
      flip_reg <= flip_next;
    end
  end

  // One command pulse per request, sent whatever the pack voltage
  assign shelfCmd = sendShelf & ~last_reg;
  assign busActivity = talk;
  // Lines are not held high unless the host pulls them up to wake the pack
  assign smbClkIn = pullHigh;
  assign smbDataIn = pullHigh | flip_reg;
endmodule

//--- bpmm_mode_manager_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench, integer model of the mode rules
module bpmm_mode_manager_tb
  import bpmm_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wrData = 16'h0000;
  logic wrStrobe = 1'b0, rdStrobe = 1'b0, measTick = 1'b0;
  logic [15:0] currMag = 16'h0000, packVoltageInput = 16'h4E20;
  logic ioActivity = 1'b0, sendShelf = 1'b0, talk = 1'b0, pullHigh = 1'b0;
  logic [DATA_W-1:0] rdData;
  logic [1:0] powerMode;
  logic shelfCmd, busActivity, smbClkIn, smbDataIn;
  logic measureEn, calcEn, displayEn, smbAccept, remcapZero, ultraLowPower;
  logic [15:0] v;
  int errors = 0, num_checks = 0, seed = 37;
  int mMode = 0, cnt = 0, tmr = 0, nS = 16, thr = 20, sleepV = 6000;
  int cur = 0, pk = 20000, cfg = 0, sEn = 1;
  int wakeLv[8] = '{6400, 6660, 8880, 9600, 9990, 11100, 12800, 13300};
  int rstTab[8] = '{8'h00, 8'hC0, 16'h1770, 8'h14, 8'h10, 1, 0, 0};

  // 25 MHz clock
  always #20 mclk = ~mclk;

  bpmm_mode_manager u_dut (.mclk, .rst_n, .addr, .wrData, .wrStrobe,
    .rdStrobe, .rdData, .measTick, .currMag, .packVoltageInput, .shelfCmd,
    .ioActivity, .busActivity, .smbClkIn, .smbDataIn, .powerMode,
    .measureEn, .calcEn, .displayEn, .smbAccept, .remcapZero, .ultraLowPower);

  bpmm_host_model u_host (.mclk, .rst_n, .sendShelf, .talk, .pullHigh,
    .shelfCmd, .busActivity, .smbClkIn, .smbDataIn);

  // ==========================================================
  // Compare, bus cycles and stimulus helpers
  task automatic chk(input logic [15:0] seen, input int exp);
    num_checks++;
    if (seen !== exp[15:0])
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp[15:0]);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge mclk);
    wrStrobe <= 1'b0;
  endtask

  // Read data only stand in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input int e);
    @(posedge mclk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge mclk);
    rdStrobe <= 1'b0;
    #1 chk(rdData, e);
  endtask

  task automatic setIn(input int c, input int p);
    @(posedge mclk);
    currMag <= c[15:0];
    packVoltageInput <= p[15:0];
    cur = c;
    pk = p;
  endtask

  // Mask bits: I/O, bus, current, voltage
  task automatic setSrc(input logic [3:0] on);
    setIn(on[1] ? 1000 : 0, on[0] ? 20000 : 3000);
    ioActivity <= on[3];
    talk <= on[2];
  endtask

  task automatic pull(input logic h);
    @(posedge mclk);
    pullHigh <= h;
  endtask

  task automatic expectMode(input int m);
    @(posedge mclk);
    #1 chk(powerMode, m);
    mMode = m;
    cnt = 0;
  endtask

  task automatic shelf(input int m);
    @(posedge mclk);
    sendShelf <= 1'b1;
    @(posedge mclk);
    sendShelf <= 1'b0;
    #1 chk(powerMode, m);
    mMode = m;
    cnt = 0;
  endtask

  // One measurement period; the model decides the mode at each measurement
  task automatic tick();
    int fire, meas, lv, old;
    @(posedge mclk);
    measTick <= 1'b1;
    @(posedge mclk);
    measTick <= 1'b0;
    old = mMode;
    lv = 0;
    if (mMode == 1)
      tmr++;
    fire = (mMode == 1) && (tmr >= nS);
    meas = (mMode == 0) || fire;
    if (fire)
      tmr = 0;
    if (meas && mMode == 1 && pk < sleepV)
      lv = 1;
    else if (meas && ((cur > thr) == (mMode == 1)))
      cnt++;
    else if (meas)
      cnt = 0;
    if (lv)
      mMode = 2;
    if (cnt >= 2 && (mMode == 1 || sEn))
    begin
      mMode = 1 - mMode;
      cnt = 0;
      tmr = 0;
    end
    // Pulses stand one cycle; a qualified Run/Sample swap lands one edge later
    #1 chk(remcapZero, lv & cfg);
    if (!lv)
    begin
      chk(measureEn, meas);
      chk(calcEn, (old < 2) ? 1 : 0);
    end
    @(posedge mclk);
    #1 chk(powerMode, mMode);
    chk({displayEn, smbAccept}, (mMode < 2) ? 3 : 0);
  endtask

  // Run stays put with a low pack; sleep comes only from Sample
  task automatic toLv();
    setIn($unsigned($random(seed)) % thr,
      sleepV - 1 - $unsigned($random(seed)) % 500);
    for (int i = 0; i < 12 && mMode != 2; i++)
      tick();
    chk(powerMode, 2);
  endtask

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++)
      rd(a[3:0], rstTab[a]);
    @(posedge mclk);
    #1 chk(rdData, 0);
    wr(OFS_STATUS, 16'hFFFF);
    rd(OFS_STATUS, 0);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 0);
    v = $random(seed);
    wr(OFS_RUN_THR, v);
    rd(OFS_RUN_THR, v);
    wr(OFS_WAKE_LVL, v);
    rd(OFS_WAKE_LVL, v[7:0]);
    wr(OFS_RUN_THR, 16'h0014);
    $display("test registers done");
    // Two-in-a-row qualification both ways, one stray measurement between
    wr(OFS_SAMPLE_INTERVAL_PERIODS, 16'h0002);
    nS = 2;
    setIn(5, 20000);
    repeat (6) tick();
    setIn(500, 20000);
    repeat (2) tick();
    setIn(5, 20000);
    repeat (2) tick();
    setIn(500, 20000);
    repeat (4) tick();
    // Sample disabled: Run holds however long the current stays low
    wr(OFS_CTRL, 16'h0000);
    sEn = 0;
    setIn(5, 20000);
    repeat (3) tick();
    setIn(500, 20000);
    repeat (2) tick();
    wr(OFS_CTRL, 16'h0001);
    sEn = 1;
    $display("test run sample done");
    // Every wake level, capacity clear set on the odd levels only
    for (int c = 0; c < 8; c++)
    begin
      cfg = c & 1;
      wr(OFS_WAKE_CFG, cfg[15:0]);
      wr(OFS_WAKE_LVL, 16'h00C0 | c[15:0]);
      toLv();
      chk(ultraLowPower, 0);
      shelf(2);
      setIn(0, wakeLv[c]);
      expectMode(2);
      setIn(0, wakeLv[c] + 1);
      expectMode(0);
      setIn(500, 20000);
      tick();
    end
    cfg = 2;
    wr(OFS_WAKE_CFG, 16'h0002);
    toLv();
    chk(ultraLowPower, 1);
    setIn(0, 20000);
    expectMode(2);
    pull(1'b1);
    expectMode(0);
    pull(1'b0);
    $display("test low voltage sleep done");
    // Storage sleep: each source alone, the others active but disabled
    for (int s = 0; s < 4; s++)
    begin
      cfg = 16 << s;
      wr(OFS_WAKE_CFG, cfg[15:0]);
      setSrc(4'hF ^ (4'h1 << s));
      shelf(3);
      chk(ultraLowPower, 0);
      expectMode(3);
      setSrc(4'hF);
      expectMode(0);
      tick();
    end
    // Current source alone at codes 0 and 31, I/O and bus still active but disabled
    cfg = 32;
    wr(OFS_WAKE_CFG, 16'h0020);
    for (int k = 0; k < 32; k += 31)
    begin
      wr(OFS_WAKE_LVL, k[15:0] << 3);
      setIn(k * 4, 3000);
      shelf(3);
      expectMode(3);
      setIn(k * 4 + 1, 3000);
      expectMode(0);
    end
    cfg = 8;
    wr(OFS_WAKE_CFG, 16'h0008);
    setSrc(4'hF);
    shelf(3);
    chk(ultraLowPower, 1);
    expectMode(3);
    pull(1'b1);
    expectMode(0);
    pull(1'b0);
    $display("test storage sleep done");
    // No wake source: only a reset gets out, mid-run reset restores defaults
    wr(OFS_WAKE_CFG, 16'h0000);
    shelf(3);
    pull(1'b1);
    expectMode(3);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1 chk({displayEn, smbAccept, powerMode}, 12);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_WAKE_CFG, 0);
    rd(OFS_SAMPLE_INTERVAL_PERIODS, 16);
    $display("test reset done");
    results();
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge mclk);
    errors++;
    results();
  end
endmodule
